// *** shared/dtc_pkg.sv ***
`default_nettype none

package dtc_pkg;

    // host port
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam logic [15:0] OFS_XFORM_CFG = 16'h20d0;
    localparam logic [15:0] OFS_TEMP_CFG = 16'h2174;

    // reset values
    localparam logic [31:0] XFORM_CFG_RST = 32'h0000_0090;
    localparam logic [31:0] TEMP_CFG_RST = 32'h0000_0000;

    // transform_config fields
    localparam int unsigned PCS_LSB = 4;
    localparam int unsigned PCS_W = 4;
    localparam int unsigned TAPER_BIT = 0;
    localparam logic [3:0] PCS_MAX = 4'hc;
    localparam int unsigned LEN_W = 15;
    localparam logic [14:0] LEN_BASE = 15'h0004;

    // temp_sensor_config fields
    localparam int unsigned CHOP_RATE_LSB = 2;
    localparam int unsigned CHOP_RATE_W = 2;
    localparam int unsigned CHOP_ON_BIT = 1;
    localparam int unsigned TEMP_EN_BIT = 0;

    // chop timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CHOP_F0_HZ = 6_250;
    localparam int unsigned CHOP_F1_HZ = 25_000;
    localparam int unsigned CHOP_F2_HZ = 100_000;
    localparam int unsigned CHOP_F3_HZ = 200_000;
    localparam int unsigned CHOP_HALF0 = CLK_HZ / (2 * CHOP_F0_HZ);
    localparam int unsigned CHOP_HALF1 = CLK_HZ / (2 * CHOP_F1_HZ);
    localparam int unsigned CHOP_HALF2 = CLK_HZ / (2 * CHOP_F2_HZ);
    localparam int unsigned CHOP_HALF3 = CLK_HZ / (2 * CHOP_F3_HZ);
    localparam int unsigned CNT_W = 13;

    typedef enum logic [1:0] {
        CHOP_6K25 = 2'b00,
        CHOP_25K = 2'b01,
        CHOP_100K = 2'b10,
        CHOP_200K = 2'b11
    } dtc_chop_rate_t;

    typedef enum logic {
        CHOP_IDLE = 1'b0,
        CHOP_RUN = 1'b1
    } dtc_chop_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } dtc_bus_req_t;

    typedef struct packed {
        logic [3:0] point_count_sel;
        logic [14:0] xform_len;
        logic taper_window_en;
        dtc_chop_rate_t chop_rate_sel;
        logic chop_on;
        logic temp_sensor_on;
        logic chop_phase;
    } dtc_cfg_t;

endpackage

`default_nettype wire

// *** src/dtc_config.sv ***
// Summary of operation
// - point_count_sel bits 7:4 select transform length 4 shifted left by code, codes above 12 acting as 12.
// - point_count_sel resets to 0x9, giving 2048 samples.
// - chop_rate_sel bits 3:2 pick 6.25, 25, 100 or 200 kHz chopping.
// - chop_on bit 1 turns temperature chopping on or off while master control bit 12 is high, resets to 0.
// - sensor enable bit 0 is stored only; master control bit 12 governs.
// - temp_sensor_config at 0x2174 resets to zero, bits 31:4 read zero.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module dtc_config #(
    parameter int unsigned CHOP_HALF_SLOW = dtc_pkg::CHOP_HALF0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // host register port
    input wire dtc_pkg::dtc_bus_req_t bus_req_i,
    output logic [31:0] rdata_o,
    // master control bit 12, same clock
    input wire logic master_temp_en_i,
    // front-end configuration
    output dtc_pkg::dtc_cfg_t cfg_o
);

    localparam logic [12:0] HALF_SLOW = 13'(CHOP_HALF_SLOW);
    localparam logic [12:0] HALF_25K = 13'(dtc_pkg::CHOP_HALF1);
    localparam logic [12:0] HALF_100K = 13'(dtc_pkg::CHOP_HALF2);
    localparam logic [12:0] HALF_200K = 13'(dtc_pkg::CHOP_HALF3);
    localparam logic [12:0] CNT_ZERO = 13'h0000;
    localparam logic [12:0] CNT_ONE = 13'h0001;

    // register fields
    logic [3:0] pcs_q;
    logic taper_q;
    dtc_pkg::dtc_chop_rate_t rate_q;
    logic chop_on_q;
    logic temp_en_q;
    logic [14:0] len_q;
    logic [31:0] rdata_q;
    logic sensor_on_q;

    // chop generator
    dtc_pkg::dtc_chop_state_t state_q;
    dtc_pkg::dtc_chop_state_t state_d;
    logic [12:0] cnt_q;
    logic phase_q;
    logic chop_run;
    logic wr_xform;
    logic wr_temp;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    // codes above the top one clamp to the longest length
    function automatic logic [14:0] len_of(input logic [3:0] code);
        logic [3:0] c;
        c = (code > dtc_pkg::PCS_MAX) ? dtc_pkg::PCS_MAX : code;
        len_of = dtc_pkg::LEN_BASE << c;
    endfunction

    // reset length worked out once, so the reset branch loads a plain constant
    localparam logic [14:0] LEN_RST =
        len_of(dtc_pkg::XFORM_CFG_RST[dtc_pkg::PCS_LSB +: dtc_pkg::PCS_W]);

    function automatic logic [12:0] half_of(input dtc_pkg::dtc_chop_rate_t r);
        unique case (r)
            dtc_pkg::CHOP_6K25: half_of = HALF_SLOW;
            dtc_pkg::CHOP_25K: half_of = HALF_25K;
            dtc_pkg::CHOP_100K: half_of = HALF_100K;
            dtc_pkg::CHOP_200K: half_of = HALF_200K;
        endcase
    endfunction

    assign wr_xform = bus_req_i.we && hit(bus_req_i.addr, dtc_pkg::OFS_XFORM_CFG);
    assign wr_temp = bus_req_i.we && hit(bus_req_i.addr, dtc_pkg::OFS_TEMP_CFG);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcs_q <= dtc_pkg::XFORM_CFG_RST[dtc_pkg::PCS_LSB +: dtc_pkg::PCS_W];
        end else if (wr_xform) begin
            pcs_q <= bus_req_i.wdata[dtc_pkg::PCS_LSB +: dtc_pkg::PCS_W];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_q <= LEN_RST;
        end else if (wr_xform) begin
            len_q <= len_of(bus_req_i.wdata[dtc_pkg::PCS_LSB +: dtc_pkg::PCS_W]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            taper_q <= dtc_pkg::XFORM_CFG_RST[dtc_pkg::TAPER_BIT];
        end else if (wr_xform) begin
            taper_q <= bus_req_i.wdata[dtc_pkg::TAPER_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rate_q <= dtc_pkg::dtc_chop_rate_t'(
                dtc_pkg::TEMP_CFG_RST[dtc_pkg::CHOP_RATE_LSB +: dtc_pkg::CHOP_RATE_W]);
            chop_on_q <= dtc_pkg::TEMP_CFG_RST[dtc_pkg::CHOP_ON_BIT];
            temp_en_q <= dtc_pkg::TEMP_CFG_RST[dtc_pkg::TEMP_EN_BIT];
        end else if (wr_temp) begin
            rate_q <= dtc_pkg::dtc_chop_rate_t'(
                bus_req_i.wdata[dtc_pkg::CHOP_RATE_LSB +: dtc_pkg::CHOP_RATE_W]);
            chop_on_q <= bus_req_i.wdata[dtc_pkg::CHOP_ON_BIT];
            temp_en_q <= bus_req_i.wdata[dtc_pkg::TEMP_EN_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_req_i.re) begin
            if (hit(bus_req_i.addr, dtc_pkg::OFS_XFORM_CFG)) begin
                rdata_q <= 32'h0000_0000;
                rdata_q[dtc_pkg::PCS_LSB +: dtc_pkg::PCS_W] <= pcs_q;
                rdata_q[dtc_pkg::TAPER_BIT] <= taper_q;
            end else if (hit(bus_req_i.addr, dtc_pkg::OFS_TEMP_CFG)) begin
                rdata_q <= 32'h0000_0000;
                rdata_q[dtc_pkg::CHOP_RATE_LSB +: dtc_pkg::CHOP_RATE_W] <= rate_q;
                rdata_q[dtc_pkg::CHOP_ON_BIT] <= chop_on_q;
                rdata_q[dtc_pkg::TEMP_EN_BIT] <= temp_en_q;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sensor_on_q <= 1'b0;
        end else begin
            sensor_on_q <= master_temp_en_i;
        end
    end

    // chopping only makes sense while the sensor is powered
    assign chop_run = chop_on_q && master_temp_en_i;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dtc_pkg::CHOP_IDLE: begin
                if (chop_run) begin
                    state_d = dtc_pkg::CHOP_RUN;
                end
            end
            dtc_pkg::CHOP_RUN: begin
                if (!chop_run) begin
                    state_d = dtc_pkg::CHOP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= dtc_pkg::CHOP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // chop half period
    // a rate change takes effect at the next phase edge, so no short pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= CNT_ZERO;
        end else if (state_q != dtc_pkg::CHOP_RUN) begin
            cnt_q <= half_of(rate_q) - CNT_ONE;
        end else if (cnt_q == CNT_ZERO) begin
            cnt_q <= half_of(rate_q) - CNT_ONE;
        end else begin
            cnt_q <= cnt_q - CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 1'b0;
        end else if (state_q != dtc_pkg::CHOP_RUN) begin
            phase_q <= 1'b0;
        end else if (cnt_q == CNT_ZERO) begin
            phase_q <= !phase_q;
        end
    end

    assign rdata_o = rdata_q;
    assign cfg_o.point_count_sel = pcs_q;
    assign cfg_o.xform_len = len_q;
    assign cfg_o.taper_window_en = taper_q;
    assign cfg_o.chop_rate_sel = rate_q;
    assign cfg_o.chop_on = chop_on_q;
    assign cfg_o.temp_sensor_on = sensor_on_q;
    assign cfg_o.chop_phase = phase_q;

    property p_len_decode;
        @(posedge clk_i) disable iff (!rst_n_i)
        (pcs_q <= dtc_pkg::PCS_MAX) |-> (len_q == (dtc_pkg::LEN_BASE << pcs_q));
    endproperty
    a_len_decode: assert property (p_len_decode)
        else $error("transform length does not match point count code");

    property p_pcs_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_xform |=> (pcs_q == $past(bus_req_i.wdata[dtc_pkg::PCS_LSB +: dtc_pkg::PCS_W]));
    endproperty
    a_pcs_write: assert property (p_pcs_write)
        else $error("point count write not stored");

    property p_reset_val;
        @(posedge clk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> (pcs_q == 4'h9 && len_q == 15'h0800 && !taper_q);
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("transform config reset value wrong");

    property p_taper_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_xform ##1 !wr_xform |-> (taper_q == $past(bus_req_i.wdata[dtc_pkg::TAPER_BIT]));
    endproperty
    a_taper_write: assert property (p_taper_write)
        else $error("window enable not held after write");

    property p_chop_reload;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == dtc_pkg::CHOP_RUN && cnt_q == CNT_ZERO && chop_run)
        |=> (cnt_q == half_of($past(rate_q)) - CNT_ONE) && ($changed(phase_q));
    endproperty
    a_chop_reload: assert property (p_chop_reload)
        else $error("chop half period reload wrong");

    property p_chop_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        // one last toggle may still land while the state machine leaves run
        !chop_on_q [*3] |-> !phase_q;
    endproperty
    a_chop_off: assert property (p_chop_off)
        else $error("chop switching while chop disabled");

    property p_master_override;
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 (sensor_on_q == $past(master_temp_en_i));
    endproperty
    a_master_override: assert property (p_master_override)
        else $error("sensor enable not following master control");

    property p_temp_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (bus_req_i.re && hit(bus_req_i.addr, dtc_pkg::OFS_TEMP_CFG))
        |=> (rdata_o[31:4] == 28'h0000000)
            && (rdata_o[3:0] == $past({rate_q, chop_on_q, temp_en_q}));
    endproperty
    a_temp_read: assert property (p_temp_read)
        else $error("temp sensor config readback wrong");

    property p_xform_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (bus_req_i.re && hit(bus_req_i.addr, dtc_pkg::OFS_XFORM_CFG))
        |=> (rdata_o == {24'h000000, $past(pcs_q), 3'b000, $past(taper_q)});
    endproperty
    a_xform_read: assert property (p_xform_read)
        else $error("transform config readback wrong");

    property p_rdata_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        !bus_req_i.re |=> (rdata_o == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");

    property p_rate_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_temp |=> (rate_q == $past(
            bus_req_i.wdata[dtc_pkg::CHOP_RATE_LSB +: dtc_pkg::CHOP_RATE_W]));
    endproperty
    a_rate_write: assert property (p_rate_write)
        else $error("chop rate write not stored");

    property p_chop_on_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_temp |=> (chop_on_q == $past(bus_req_i.wdata[dtc_pkg::CHOP_ON_BIT]));
    endproperty
    a_chop_on_write: assert property (p_chop_on_write)
        else $error("chop control write not stored");

endmodule

`default_nettype wire

// *** tb/dtc_config_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module dtc_config_tb;
    // short slow chop half period keeps the run brief
    localparam int unsigned HALF_SLOW = 16;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic master_temp_en_i = 1'b0;
    dtc_pkg::dtc_bus_req_t bus_req_i = '0;
    logic [31:0] rdata_o;
    dtc_pkg::dtc_cfg_t cfg_o;
    int err_count = 0;
    int comparisons = 0;

    always #5 clk_i = ~clk_i;

    dtc_config #(.CHOP_HALF_SLOW(HALF_SLOW)) dtc_config_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus_req_i(bus_req_i),
        .rdata_o(rdata_o),
        .master_temp_en_i(master_temp_en_i),
        .cfg_o(cfg_o)
    );

    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_req_i.addr <= a;
        bus_req_i.wdata <= d;
        bus_req_i.we <= 1'b1;
        @(posedge clk_i);
        bus_req_i.we <= 1'b0;
        #1;
    endtask

    // read data stand one cycle only, then fall back to zero
    task automatic read_chk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_req_i.addr <= a;
        bus_req_i.re <= 1'b1;
        @(posedge clk_i);
        bus_req_i.re <= 1'b0;
        #1;
        check("read data", rdata_o, exp);
        @(posedge clk_i);
        #1;
        check("read data after", rdata_o, 32'h0);
    endtask

    task automatic next_toggle(output int n);
        logic p;
        p = cfg_o.chop_phase;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 5000) begin
                check("chop toggle wait", 32'h1, 32'h0);
                give_verdict();
            end
        end while (cfg_o.chop_phase === p);
    endtask

    task automatic xform_codes();
        for (int c = 0; c < 16; c++) begin
            if (c == 13) c = 15;
            // reserved bits 3:1 written as ones must read back zero
            write_reg(dtc_pkg::OFS_XFORM_CFG, {24'h0, 4'(c), 3'b111, 1'(c)});
            check("point_count_sel", 32'(cfg_o.point_count_sel), 32'(c));
            check("xform_len", 32'(cfg_o.xform_len), (c > 12) ? 32'd16384 : 32'd4 << c);
            check("taper", 32'(cfg_o.taper_window_en), 32'(c % 2));
            read_chk(dtc_pkg::OFS_XFORM_CFG, {24'h0, 4'(c), 3'b000, 1'(c)});
        end
    endtask

    task automatic temp_fields();
        for (int v = 0; v < 16; v++) begin
            write_reg(dtc_pkg::OFS_TEMP_CFG, 32'hffff_fff0 | 32'(v));
            check("chop_rate_sel", 32'(cfg_o.chop_rate_sel), 32'(v / 4));
            check("chop_on", 32'(cfg_o.chop_on), 32'((v / 2) % 2));
            read_chk(dtc_pkg::OFS_TEMP_CFG, 32'(v));
        end
        // unmapped place: write ignored, read gives zero
        write_reg(16'h2178, 32'h0000_000f);
        read_chk(16'h2178, 32'h0);
        read_chk(dtc_pkg::OFS_TEMP_CFG, 32'h0000_000f);
    endtask

    task automatic chop_rates();
        int n;
        int half [4];
        int n1;
        half = '{HALF_SLOW, 2000, 500, 250};
        write_reg(dtc_pkg::OFS_TEMP_CFG, 32'h0);
        @(posedge clk_i);
        master_temp_en_i <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            write_reg(dtc_pkg::OFS_TEMP_CFG, {28'h0, 2'(r), 2'b10});
            // the first toggle after a rate change still uses the old count
            next_toggle(n);
            next_toggle(n);
            check("chop half period", 32'(n), 32'(half[r]));
            n1 = n;
            next_toggle(n);
            check("chop half period", 32'(n), 32'(half[r]));
            // the reader pairs two samples, so both chop levels must last alike
            check("chop level balance", 32'(n), 32'(n1));
        end
        write_reg(dtc_pkg::OFS_TEMP_CFG, 32'h0000_000c);
        repeat (3) @(posedge clk_i);
        #1;
        check("chop_phase off", 32'(cfg_o.chop_phase), 32'h0);
    endtask

    task automatic sensor_override();
        write_reg(dtc_pkg::OFS_TEMP_CFG, 32'h0000_0003);
        @(posedge clk_i);
        master_temp_en_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        check("temp_sensor_on", 32'(cfg_o.temp_sensor_on), 32'h0);
        check("chop_phase no master", 32'(cfg_o.chop_phase), 32'h0);
        @(posedge clk_i);
        master_temp_en_i <= 1'b1;
        @(posedge clk_i);
        #1;
        check("temp_sensor_on", 32'(cfg_o.temp_sensor_on), 32'h1);
        write_reg(dtc_pkg::OFS_TEMP_CFG, 32'h0);
        check("temp_sensor_on", 32'(cfg_o.temp_sensor_on), 32'h1);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("point_count_sel reset", 32'(cfg_o.point_count_sel), 32'h9);
        check("xform_len reset", 32'(cfg_o.xform_len), 32'd2048);
        check("taper reset", 32'(cfg_o.taper_window_en), 32'h0);
        check("chop_on reset", 32'(cfg_o.chop_on), 32'h0);
        read_chk(dtc_pkg::OFS_XFORM_CFG, 32'h0000_0090);
        read_chk(dtc_pkg::OFS_TEMP_CFG, 32'h0);
        xform_codes();
        temp_fields();
        chop_rates();
        sensor_override();
        give_verdict();
    end
endmodule

`default_nettype wire
